// [flp_map.svh]
// Register offsets, field positions, reset values and timing counts for the FLP block
`ifndef FLP_MAP_SVH
`define FLP_MAP_SVH

// Management register offsets
`define REG_BASIC_CTRL      5'h00
`define REG_MMD_CTRL        5'h0D
`define REG_MMD_DATA        5'h0E

// Basic control fields
`define CTRL_RESTART_AN_BIT 9
`define CTRL_AN_EN_BIT      12
`define CTRL_AN_EN_RESET    1'b1

// MMD access control fields
`define MMD_FUNC_MSB        15
`define MMD_FUNC_LSB        14
`define MMD_DEVAD_MSB       4
`define MMD_DEVAD_TIMING    5'h00

// MMD timing registers, interval counted in reference clock ticks
`define MMD_REG_BTB_LO      16'h0003
`define MMD_REG_BTB_HI      16'h0004
`define BTB_LO_RESET        16'h0D40
`define BTB_HI_RESET        16'h0003
`define BTB_MIN_TICKS       20'h3_0D40
`define BTB_MAX_TICKS       20'h9_27C0

// Management frame layout
`define PREAMBLE_BITS       6'h20
`define HDR_LAST_BIT        5'h0D
`define DATA_LAST_BIT       5'h0F
`define OP_WRITE            2'b01
`define OP_READ             2'b10

// Clocking: 100 MHz system clock, 25 MHz reference tick
`define SYS_CLK_NS          10
`define REF_TICK_LAST       2'h3

// Burst shape
`define FLP_PW_NS           100
`define FLP_CTD_NS          64000
`define FLP_PW_CYCLES       (`FLP_PW_NS / `SYS_CLK_NS)
`define FLP_CTD_CYCLES      (`FLP_CTD_NS / `SYS_CLK_NS)
`define FLP_LAST_SLOT       6'h20

`endif

// [flp_pkg.sv]
// Types shared by the FLP timing block
package flp_pkg;

    typedef enum logic [1:0] {
        MD_PRE  = 2'b00,
        MD_HDR  = 2'b01,
        MD_TA   = 2'b10,
        MD_DATA = 2'b11
    } md_state_t;

    typedef enum logic [2:0] {
        FL_IDLE    = 3'b000,
        FL_LOAD_LO = 3'b001,
        FL_LOAD_HI = 3'b010,
        FL_LATCH   = 3'b011,
        FL_BURST   = 3'b100,
        FL_GAP     = 3'b101
    } flp_state_t;

    typedef enum logic [1:0] {
        MMD_FN_ADDR    = 2'b00,
        MMD_FN_DATA    = 2'b01,
        MMD_FN_INC_RW  = 2'b10,
        MMD_FN_INC_WR  = 2'b11
    } mmd_func_t;

endpackage

// [mmd_mem_if.sv]
// Carrier between the register logic and the MMD register store
`timescale 1ns/1ns
interface mmd_mem_if #(
    parameter int unsigned AW = 4
);
    logic          wr_en;
    logic [AW-1:0] wr_addr;
    logic [15:0]   wr_data;
    logic [AW-1:0] rda_addr;
    logic [15:0]   rda_data;
    logic [AW-1:0] rdb_addr;
    logic [15:0]   rdb_data;

    modport owner (
        output wr_en,
        output wr_addr,
        output wr_data,
        output rda_addr,
        output rdb_addr,
        input  rda_data,
        input  rdb_data
    );

    modport store (
        input  wr_en,
        input  wr_addr,
        input  wr_data,
        input  rda_addr,
        input  rdb_addr,
        output rda_data,
        output rdb_data
    );
endinterface

// [flp_mmd_store.sv]
// MMD device register store with two registered read ports
`timescale 1ns/1ns
`include "flp_map.svh"
module flp_mmd_store #(
    parameter int unsigned DEPTH = 16,
    parameter int unsigned AW    = 4
) (
    // Clock and reset
    input  wire logic sys_clk,
    input  wire logic resetn,
    // Access port
    mmd_mem_if.store  mem
);

    logic [15:0] regs_ff [DEPTH];

    // Timing registers come up at the 8 ms default
    function automatic logic [15:0] reset_value(input int unsigned idx);
        logic [15:0] v;
        v = 16'h0000;
        if (idx == int'(`MMD_REG_BTB_LO)) begin
            v = `BTB_LO_RESET;
        end else if (idx == int'(`MMD_REG_BTB_HI)) begin
            v = `BTB_HI_RESET;
        end
        return v;
    endfunction

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            for (int unsigned i = 0; i < DEPTH; i++) begin
                regs_ff[i] <= reset_value(i);
            end
        end else if (mem.wr_en) begin
            regs_ff[mem.wr_addr] <= mem.wr_data;
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            mem.rda_data <= 16'h0000;
            mem.rdb_data <= 16'h0000;
        end else begin
            mem.rda_data <= regs_ff[mem.rda_addr];
            mem.rdb_data <= regs_ff[mem.rdb_addr];
        end
    end

endmodule

// [flp_burst_timing_config.sv]
// FLP burst generator with management-programmable burst interval
`timescale 1ns/1ns
`include "flp_map.svh"
module flp_burst_timing_config #(
    parameter int unsigned CTD_CYCLES = `FLP_CTD_CYCLES,
    parameter int unsigned PW_CYCLES  = `FLP_PW_CYCLES,
    parameter int unsigned MMD_DEPTH  = 16,
    parameter int unsigned MMD_AW     = 4
) (
    // Clock and reset
    input  wire logic        sys_clk,
    input  wire logic        resetn,
    // Management serial interface
    input  wire logic        mdc,
    input  wire logic        mdio_in,
    output logic             mdio_out,
    output logic             mdio_oe,
    input  wire logic [4:0]  phy_addr,
    // Auto-negotiation
    input  wire logic [15:0] an_code_word,
    output logic             an_enabled,
    // Line side
    output logic             flp_pulse,
    output logic             flp_burst_active
);

    mmd_mem_if #(.AW(MMD_AW)) mem_bus ();

    flp_mmd_store #(
        .DEPTH (MMD_DEPTH),
        .AW    (MMD_AW)
    ) u_store (
        .sys_clk (sys_clk),
        .resetn  (resetn),
        .mem     (mem_bus.store)
    );

    // Management frame state
    flp_pkg::md_state_t md_state_ff;
    logic [5:0]         pre_cnt_ff;
    logic [4:0]         bit_cnt_ff;
    logic [13:0]        hdr_ff;
    logic [15:0]        wdata_ff;
    logic [15:0]        rdata_ff;
    logic               mdc_prev_ff;
    logic               mdio_out_ff;
    logic               mdio_oe_ff;

    // Register state
    logic               an_en_ff;
    logic               restart_pend_ff;
    flp_pkg::mmd_func_t mmd_func_ff;
    logic [4:0]         mmd_devad_ff;
    logic [15:0]        mmd_addr_ff;

    // Burst generator state
    flp_pkg::flp_state_t fl_state_ff;
    logic [1:0]          ref_div_ff;
    logic [15:0]         btb_lo_ff;
    logic [19:0]         interval_ff;
    logic [19:0]         btb_cnt_ff;
    logic [13:0]         slot_cnt_ff;
    logic [5:0]          slot_idx_ff;
    logic [15:0]         code_ff;
    logic                flp_pulse_ff;

    logic               mdc_rise;
    logic               req_ok;
    logic               is_rd;
    logic               is_wr;
    logic [4:0]         req_reg;
    logic               wr_commit;
    logic               rd_done;
    logic [15:0]        wr_word;
    logic               mmd_hit;
    logic               mmd_data_fn;
    logic               mmd_inc_wr;
    logic               mmd_inc_rd;
    logic [15:0]        read_word;
    logic               ref_tick;
    logic               restart_take;
    logic               slot_end;
    logic               pulse_slot;

    // Interval clamped so the spacing never leaves its legal window
    function automatic logic [19:0] clamp_btb(input logic [31:0] ticks);
        logic [19:0] v;
        if (ticks < {12'h000, `BTB_MIN_TICKS}) begin
            v = `BTB_MIN_TICKS;
        end else if (ticks > {12'h000, `BTB_MAX_TICKS}) begin
            v = `BTB_MAX_TICKS;
        end else begin
            v = ticks[19:0];
        end
        return v;
    endfunction

    // Only MMD device 0 words that exist in the store are addressable
    function automatic logic mmd_in_range(input logic [4:0] devad, input logic [15:0] addr);
        return (devad == `MMD_DEVAD_TIMING) && ({16'h0000, addr} < 32'(MMD_DEPTH));
    endfunction

    assign mdc_rise    = mdc & ~mdc_prev_ff;
    assign req_reg     = hdr_ff[4:0];
    assign req_ok      = (hdr_ff[13:12] == 2'b01) && (hdr_ff[9:5] == phy_addr);
    assign is_rd       = req_ok && (hdr_ff[11:10] == `OP_READ);
    assign is_wr       = req_ok && (hdr_ff[11:10] == `OP_WRITE);
    assign wr_word     = {wdata_ff[14:0], mdio_in};
    assign wr_commit   = mdc_rise && (md_state_ff == flp_pkg::MD_DATA)
                         && (bit_cnt_ff == `DATA_LAST_BIT) && is_wr;
    assign rd_done     = mdc_rise && (md_state_ff == flp_pkg::MD_DATA)
                         && (bit_cnt_ff == `DATA_LAST_BIT) && is_rd;
    assign mmd_hit     = mmd_in_range(mmd_devad_ff, mmd_addr_ff);
    assign mmd_data_fn = (mmd_func_ff != flp_pkg::MMD_FN_ADDR);
    assign mmd_inc_wr  = (mmd_func_ff == flp_pkg::MMD_FN_INC_RW)
                         || (mmd_func_ff == flp_pkg::MMD_FN_INC_WR);
    assign mmd_inc_rd  = (mmd_func_ff == flp_pkg::MMD_FN_INC_RW);

    // Store ports: host side follows the latched MMD address
    assign mem_bus.wr_en    = wr_commit && (req_reg == `REG_MMD_DATA)
                              && mmd_data_fn && mmd_hit;
    assign mem_bus.wr_addr  = mmd_addr_ff[MMD_AW-1:0];
    assign mem_bus.wr_data  = wr_word;
    assign mem_bus.rda_addr = mmd_addr_ff[MMD_AW-1:0];
    assign mem_bus.rdb_addr = MMD_AW'((fl_state_ff == flp_pkg::FL_LOAD_LO)
                              ? `MMD_REG_BTB_LO : `MMD_REG_BTB_HI);

    // Read value chosen when the turnaround starts, one mdc period after the last header bit
    always_comb begin
        read_word = 16'h0000;
        case (req_reg)
            `REG_BASIC_CTRL: begin
                read_word[`CTRL_AN_EN_BIT]      = an_en_ff;
                read_word[`CTRL_RESTART_AN_BIT] = restart_pend_ff;
            end
            `REG_MMD_CTRL: begin
                read_word = {mmd_func_ff, 9'h000, mmd_devad_ff};
            end
            `REG_MMD_DATA: begin
                if (!mmd_data_fn) begin
                    read_word = mmd_addr_ff;
                end else if (mmd_hit) begin
                    read_word = mem_bus.rda_data;
                end
            end
            default: read_word = 16'h0000;
        endcase
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            // Pin idles high, so no false edge follows reset
            mdc_prev_ff <= 1'b1;
        end else begin
            mdc_prev_ff <= mdc;
        end
    end

    // Management frame receiver and read-data driver
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            md_state_ff <= flp_pkg::MD_PRE;
            pre_cnt_ff  <= 6'h00;
            bit_cnt_ff  <= 5'h00;
            hdr_ff      <= 14'h0000;
            wdata_ff    <= 16'h0000;
            rdata_ff    <= 16'h0000;
            mdio_out_ff <= 1'b0;
            mdio_oe_ff  <= 1'b0;
        end else if (mdc_rise) begin
            case (md_state_ff)
                flp_pkg::MD_PRE: begin
                    if (mdio_in) begin
                        if (pre_cnt_ff != `PREAMBLE_BITS) begin
                            pre_cnt_ff <= pre_cnt_ff + 6'h01;
                        end
                    end else if (pre_cnt_ff == `PREAMBLE_BITS) begin
                        md_state_ff <= flp_pkg::MD_HDR;
                        hdr_ff      <= 14'h0000;
                        bit_cnt_ff  <= 5'h01;
                        pre_cnt_ff  <= 6'h00;
                    end else begin
                        pre_cnt_ff <= 6'h00;
                    end
                end
                flp_pkg::MD_HDR: begin
                    hdr_ff     <= {hdr_ff[12:0], mdio_in};
                    bit_cnt_ff <= bit_cnt_ff + 5'h01;
                    if (bit_cnt_ff == `HDR_LAST_BIT) begin
                        md_state_ff <= flp_pkg::MD_TA;
                        bit_cnt_ff  <= 5'h00;
                    end
                end
                flp_pkg::MD_TA: begin
                    if (bit_cnt_ff == 5'h00) begin
                        bit_cnt_ff <= 5'h01;
                        rdata_ff   <= read_word;
                        if (is_rd) begin
                            mdio_oe_ff  <= 1'b1;
                            mdio_out_ff <= 1'b0;
                        end
                    end else begin
                        md_state_ff <= flp_pkg::MD_DATA;
                        bit_cnt_ff  <= 5'h00;
                        if (is_rd) begin
                            mdio_out_ff <= rdata_ff[15];
                            rdata_ff    <= {rdata_ff[14:0], 1'b0};
                        end
                    end
                end
                flp_pkg::MD_DATA: begin
                    wdata_ff   <= wr_word;
                    bit_cnt_ff <= bit_cnt_ff + 5'h01;
                    if (is_rd) begin
                        mdio_out_ff <= rdata_ff[15];
                        rdata_ff    <= {rdata_ff[14:0], 1'b0};
                    end
                    if (bit_cnt_ff == `DATA_LAST_BIT) begin
                        md_state_ff <= flp_pkg::MD_PRE;
                        bit_cnt_ff  <= 5'h00;
                        mdio_oe_ff  <= 1'b0;
                        mdio_out_ff <= 1'b0;
                    end
                end
                default: begin
                    md_state_ff <= flp_pkg::MD_PRE;
                    mdio_oe_ff  <= 1'b0;
                end
            endcase
        end
    end

    // Basic control: enable and restart; a new restart beats the loader's clear
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            an_en_ff        <= `CTRL_AN_EN_RESET;
            restart_pend_ff <= 1'b1;
        end else begin
            if (restart_take) begin
                restart_pend_ff <= 1'b0;
            end
            if (wr_commit && (req_reg == `REG_BASIC_CTRL)) begin
                an_en_ff <= wr_word[`CTRL_AN_EN_BIT];
                if (wr_word[`CTRL_RESTART_AN_BIT]
                    || (wr_word[`CTRL_AN_EN_BIT] && !an_en_ff)) begin
                    restart_pend_ff <= 1'b1;
                end
            end
        end
    end

    // Indirect MMD access: function and device, then address or data
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            mmd_func_ff  <= flp_pkg::MMD_FN_ADDR;
            mmd_devad_ff <= 5'h00;
            mmd_addr_ff  <= 16'h0000;
        end else if (wr_commit && (req_reg == `REG_MMD_CTRL)) begin
            mmd_func_ff  <= flp_pkg::mmd_func_t'(wr_word[`MMD_FUNC_MSB:`MMD_FUNC_LSB]);
            mmd_devad_ff <= wr_word[`MMD_DEVAD_MSB:0];
        end else if (wr_commit && (req_reg == `REG_MMD_DATA)) begin
            if (!mmd_data_fn) begin
                mmd_addr_ff <= wr_word;
            end else if (mmd_inc_wr) begin
                mmd_addr_ff <= mmd_addr_ff + 16'h0001;
            end
        end else if (rd_done && (req_reg == `REG_MMD_DATA) && mmd_inc_rd) begin
            mmd_addr_ff <= mmd_addr_ff + 16'h0001;
        end
    end

    // Reference tick: interval registers count 25 MHz periods
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            ref_div_ff <= 2'h0;
        end else begin
            ref_div_ff <= ref_div_ff + 2'h1;
        end
    end

    assign ref_tick     = (ref_div_ff == `REF_TICK_LAST);
    assign restart_take = restart_pend_ff && an_en_ff && (fl_state_ff != flp_pkg::FL_LOAD_LO)
                          && (fl_state_ff != flp_pkg::FL_LOAD_HI)
                          && (fl_state_ff != flp_pkg::FL_LATCH);
    assign slot_end     = (slot_cnt_ff == 14'(CTD_CYCLES - 1));
    // Even slots are clock pulses, odd slots carry code bits
    assign pulse_slot   = !slot_idx_ff[0] || code_ff[slot_idx_ff[4:1]];

    // Burst sequencer: the interval is only picked up on a restart
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            fl_state_ff  <= flp_pkg::FL_IDLE;
            btb_lo_ff    <= 16'h0000;
            interval_ff  <= `BTB_MIN_TICKS;
            btb_cnt_ff   <= 20'h0_0000;
            slot_cnt_ff  <= 14'h0000;
            slot_idx_ff  <= 6'h00;
            code_ff      <= 16'h0000;
            flp_pulse_ff <= 1'b0;
        end else if (!an_en_ff) begin
            fl_state_ff  <= flp_pkg::FL_IDLE;
            flp_pulse_ff <= 1'b0;
        end else if (restart_take) begin
            fl_state_ff  <= flp_pkg::FL_LOAD_LO;
            flp_pulse_ff <= 1'b0;
        end else begin
            case (fl_state_ff)
                flp_pkg::FL_IDLE: begin
                    flp_pulse_ff <= 1'b0;
                end
                flp_pkg::FL_LOAD_LO: begin
                    fl_state_ff <= flp_pkg::FL_LOAD_HI;
                end
                flp_pkg::FL_LOAD_HI: begin
                    btb_lo_ff   <= mem_bus.rdb_data;
                    fl_state_ff <= flp_pkg::FL_LATCH;
                end
                flp_pkg::FL_LATCH: begin
                    interval_ff <= clamp_btb({mem_bus.rdb_data, btb_lo_ff});
                    fl_state_ff <= flp_pkg::FL_BURST;
                    btb_cnt_ff  <= 20'h0_0000;
                    slot_cnt_ff <= 14'h0000;
                    slot_idx_ff <= 6'h00;
                    code_ff     <= an_code_word;
                end
                flp_pkg::FL_BURST: begin
                    if (ref_tick) begin
                        btb_cnt_ff <= btb_cnt_ff + 20'h0_0001;
                    end
                    flp_pulse_ff <= (slot_cnt_ff < 14'(PW_CYCLES)) && pulse_slot;
                    slot_cnt_ff  <= slot_end ? 14'h0000 : slot_cnt_ff + 14'h0001;
                    if (slot_end) begin
                        slot_idx_ff <= slot_idx_ff + 6'h01;
                        if (slot_idx_ff == `FLP_LAST_SLOT) begin
                            fl_state_ff <= flp_pkg::FL_GAP;
                        end
                    end
                end
                flp_pkg::FL_GAP: begin
                    flp_pulse_ff <= 1'b0;
                    if (ref_tick) begin
                        if (btb_cnt_ff >= interval_ff - 20'h0_0001) begin
                            fl_state_ff <= flp_pkg::FL_BURST;
                            btb_cnt_ff  <= 20'h0_0000;
                            slot_cnt_ff <= 14'h0000;
                            slot_idx_ff <= 6'h00;
                            code_ff     <= an_code_word;
                        end else begin
                            btb_cnt_ff <= btb_cnt_ff + 20'h0_0001;
                        end
                    end
                end
                default: begin
                    fl_state_ff <= flp_pkg::FL_IDLE;
                end
            endcase
        end
    end

    assign mdio_out         = mdio_out_ff;
    assign mdio_oe          = mdio_oe_ff;
    assign an_enabled       = an_en_ff;
    assign flp_pulse        = flp_pulse_ff;
    assign flp_burst_active = (fl_state_ff == flp_pkg::FL_BURST);

endmodule

// [flp_burst_timing_config_assertions.sv]
// Port-level checker for the FLP burst timing block
`timescale 1ns/1ns
module flp_burst_timing_config_assertions #(
    parameter int unsigned CTD_CYCLES = 6400,
    parameter int unsigned PW_CYCLES  = 10
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic resetn,
    // Observed outputs
    input wire logic mdio_out,
    input wire logic mdio_oe,
    input wire logic an_enabled,
    input wire logic flp_pulse,
    input wire logic flp_burst_active
);
    int gap_ff, hi_ff, npulse_ff, len_ff, post_ff;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    // Long spans live in counters so the properties stay short
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            gap_ff    <= 0;
            hi_ff     <= 0;
            npulse_ff <= 0;
            len_ff    <= 0;
            post_ff   <= 0;
        end else begin
            gap_ff    <= (flp_pulse && hi_ff == 0) ? 1 : gap_ff + 1;
            hi_ff     <= flp_pulse ? hi_ff + 1 : 0;
            npulse_ff <= (flp_burst_active && len_ff == 0) ? 0
                         : npulse_ff + int'(flp_pulse && hi_ff == 0);
            len_ff    <= flp_burst_active ? len_ff + 1 : 0;
            post_ff   <= (post_ff < 8) ? post_ff + 1 : post_ff;
        end
    end
    default_burst_a: assert property (post_ff == 6 |-> flp_burst_active)
        else $error("No burst shortly after reset");
    first_pulse_a: assert property ($rose(flp_burst_active) |=> flp_pulse)
        else $error("Burst did not open with a clock pulse");
    pulse_width_a: assert property ($fell(flp_pulse) && an_enabled
        |-> hi_ff == PW_CYCLES)
        else $error("Pulse width wrong");
    pulse_spacing_a: assert property (flp_pulse && hi_ff == 0 && npulse_ff != 0
        |-> gap_ff == CTD_CYCLES || gap_ff == 2 * CTD_CYCLES)
        else $error("Pulse spacing wrong");
    pulse_count_a: assert property ($fell(flp_burst_active) && an_enabled
        |-> npulse_ff inside {[17:33]})
        else $error("Pulse count per burst out of range");
    burst_len_a: assert property ($fell(flp_burst_active) && an_enabled
        |-> len_ff inside {[33 * CTD_CYCLES - 1 : 33 * CTD_CYCLES + 1]})
        else $error("Burst length wrong");
    pulse_in_burst_a: assert property (flp_pulse
        |-> flp_burst_active || $past(flp_burst_active))
        else $error("Pulse outside a burst");
    an_off_quiet_a: assert property (!an_enabled && !$past(an_enabled) |-> !flp_pulse)
        else $error("Pulse while negotiation disabled");
    mdio_idle_a: assert property (!mdio_oe |-> !mdio_out)
        else $error("Data driven while not enabled");
    ta_low_a: assert property ($rose(mdio_oe) |-> !mdio_out ##1 mdio_oe [*3])
        else $error("Turnaround bit wrong");
    burst_c: cover property ($fell(flp_burst_active));
    read_c: cover property ($rose(mdio_oe));
    an_off_c: cover property ($fell(an_enabled));
endmodule
bind flp_burst_timing_config flp_burst_timing_config_assertions #(
    .CTD_CYCLES(CTD_CYCLES), .PW_CYCLES(PW_CYCLES)) chk (
    .sys_clk(sys_clk), .resetn(resetn), .mdio_out(mdio_out), .mdio_oe(mdio_oe),
    .an_enabled(an_enabled), .flp_pulse(flp_pulse), .flp_burst_active(flp_burst_active));

// [flp_link_partner.sv]
// Behavioural link partner that decodes FLP bursts from the line
`timescale 1ns/1ns
module flp_link_partner #(
    parameter int CTD_CYCLES = 20
) (
    // Clock and reset
    input  wire logic        sys_clk,
    input  wire logic        resetn,
    // Line
    input  wire logic        flp_pulse,
    // Decoded burst
    output logic             rx_done,
    output logic [15:0]      rx_word,
    output logic [7:0]       rx_count
);
    int          since, slot, cnt;
    logic        prev;
    logic [15:0] word;
    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            rx_done  <= 1'b0;
            rx_word  <= 16'h0000;
            rx_count <= 8'h00;
            cnt = 0;
            since = 0;
            prev = 1'b0;
            word = 16'h0000;
        end else begin
            rx_done <= 1'b0;
            since = since + 1;
            if (flp_pulse && !prev) begin
                // Rounded slot index tolerates a cycle or two of jitter
                slot = (cnt == 0) ? 0
                     : slot + (since + CTD_CYCLES / 2) / CTD_CYCLES;
                if (slot % 2 == 1 && slot < 32) word[slot / 2] = 1'b1;
                cnt = cnt + 1;
                since = 0;
            end
            if (cnt != 0 && since == 3 * CTD_CYCLES) begin
                rx_done  <= 1'b1;
                rx_word  <= word;
                rx_count <= 8'(cnt);
                cnt = 0;
                word = 16'h0000;
            end
            prev = flp_pulse;
        end
    end
endmodule

// [flp_burst_timing_config_tb.sv]
// Self-checking testbench for the FLP burst timing block
`timescale 1ns/1ns
module flp_burst_timing_config_tb;
    logic        sys_clk, resetn, mdc, drv, mdio_in, mdio_out, mdio_oe;
    logic        an_enabled, flp_pulse, flp_burst_active, rx_done;
    logic [4:0]  phy;
    logic [15:0] code, r, rx_word;
    logic [7:0]  rx_count;
    logic [23:0] exp_q [$];
    int          seed, num_errors, checked;
    logic [15:0] walk [8] = '{16'h0000, 16'h0004, 16'h4000, 16'h0006,
                              16'h0000, 16'h0003, 16'h4000, 16'h1a80};
    // Shared pin: device drive wins, otherwise the pull-up or the bench
    assign mdio_in = mdio_oe ? mdio_out : drv;
    flp_burst_timing_config #(.CTD_CYCLES(20), .PW_CYCLES(2)) dut (
        .sys_clk(sys_clk), .resetn(resetn), .mdc(mdc), .mdio_in(mdio_in),
        .mdio_out(mdio_out), .mdio_oe(mdio_oe), .phy_addr(phy), .an_code_word(code),
        .an_enabled(an_enabled), .flp_pulse(flp_pulse), .flp_burst_active(flp_burst_active));
    flp_link_partner #(.CTD_CYCLES(20)) partner (
        .sys_clk(sys_clk), .resetn(resetn), .flp_pulse(flp_pulse),
        .rx_done(rx_done), .rx_word(rx_word), .rx_count(rx_count));
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic complete_run();
        $display("Checks %0d, errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // One management frame, MSB first; read data taken just before mdc rises
    task automatic mdio(input logic [1:0] op, input logic [4:0] pa, input logic [4:0] ra,
                        input logic [15:0] wd, output logic [15:0] rd);
        logic [63:0] f;
        f = {32'hffff_ffff, 2'b01, op, pa, ra, 2'b10, wd};
        for (int i = 63; i >= 0; i--) begin
            drv = (op == 2'b10 && i < 18) ? 1'b1 : f[i];
            mdc = 1'b0;
            repeat (2) @(negedge sys_clk);
            if (i < 16) rd[i] = mdio_in;
            mdc = 1'b1;
            repeat (2) @(negedge sys_clk);
        end
        mdc = 1'b0;
        drv = 1'b1;
        @(negedge sys_clk);
    endtask
    task automatic wr(input logic [4:0] ra, input logic [15:0] d);
        logic [15:0] x;
        mdio(2'b01, phy, ra, d, x);
    endtask
    task automatic mmd_rd(input logic [4:0] ra, input logic [15:0] exp);
        wr(5'h0d, 16'h0000);
        wr(5'h0e, {11'h000, ra});
        wr(5'h0d, 16'h4000);
        mdio(2'b10, phy, 5'h0e, 16'h0000, r);
        chk(24'(r), 24'(exp));
    endtask
    task automatic drain();
        for (int i = 0; i < 3000 && exp_q.size() != 0; i++) @(negedge sys_clk);
        if (exp_q.size() != 0) begin
            num_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, 24'h0, exp_q[0]);
            complete_run();
        end
    endtask
    task automatic expect_burst();
        code = 16'($random(seed));
        exp_q.push_back({8'(17 + $countones(code)), code});
    endtask
    // Each decoded burst takes the oldest expectation
    always @(negedge sys_clk) begin
        if (rx_done === 1'b1) begin
            chk({rx_count, rx_word}, exp_q.size() != 0 ? exp_q.pop_front() : 24'hff_ffff);
        end
    end
    initial begin
        seed = 18;
        mdc = 1'b0;
        drv = 1'b1;
        resetn = 1'b0;
        phy = 5'($random(seed));
        expect_burst();
        repeat (2) @(negedge sys_clk);
        resetn = 1'b1;
        drain();
        $display("Test burst after reset done");
        mmd_rd(5'h04, 16'h0003);
        mmd_rd(5'h03, 16'h0d40);
        mdio(2'b10, phy, 5'h05, 16'h0000, r);
        chk(24'(r), 24'h0);
        $display("Test reset values done");
        for (int i = 0; i < 8; i++) wr(i % 2 ? 5'h0e : 5'h0d, walk[i]);
        mmd_rd(5'h04, 16'h0006);
        mmd_rd(5'h03, 16'h1a80);
        mdio(2'b01, phy ^ 5'h01, 5'h0e, 16'hffff, r);
        mmd_rd(5'h03, 16'h1a80);
        $display("Test interval programming done");
        expect_burst();
        wr(5'h00, 16'h1200);
        drain();
        mdio(2'b10, phy, 5'h00, 16'h0000, r);
        chk(24'(r & 16'h1200), 24'h1000);
        $display("Test restart done");
        wr(5'h00, 16'h0000);
        chk(24'(an_enabled), 24'h0);
        expect_burst();
        wr(5'h00, 16'h1000);
        chk(24'(an_enabled), 24'h1);
        drain();
        $display("Test enable toggle done");
        complete_run();
    end
endmodule
